// File: src/fault_rec_pkg.sv
// Constants, types and codes shared by the fault snapshot recorder.
// Assumes one 100 MHz clock and an active-high asynchronous reset.
// What this block does
// - On the chosen trigger, capture every selected magnitude into a new record.
// - Capture happens on the trigger cycle itself, no extra delay stage.
// - Trigger source selectable: protection trip or any user trigger.
// - One setting picks per-unit or primary values for all channels.
// - Up to eight channels, each selecting one source from the measurement set.
// - Separate enables store overcurrent and/or voltage fault-type codes.
// - Record holds tripped stage and fault codes, forwarded upstream.
// - Twelve newest records kept, readable by the local display.
// - Fault display shows values when the trip came from a listed stage.
// - Sources limited to inputs present: current-only or voltage-only variants.
// - Overcurrent code is one of seven phase/ground combinations.
// - Voltage code covers phases plus frequency, power, thermal, unbalance, harmonic, residual.
package fault_rec_pkg;
  localparam int unsigned CHANNELS  = 8;
  localparam int unsigned DEPTH     = 12;
  localparam int unsigned SRC_W     = 6;
  localparam int unsigned SRC_COUNT = 64;
  localparam int unsigned MAG_W     = 16;
  localparam int unsigned STAGE_W   = 6;
  localparam int unsigned GROUP_W   = 3;
  localparam int unsigned TS_W      = 32;
  localparam int unsigned CLK_MHZ   = 100;
  localparam int unsigned MS_NS     = 1000000;
  localparam int unsigned CLK_NS    = 1000 / CLK_MHZ;
  localparam int unsigned MS_CYCLES = MS_NS / CLK_NS;
  // source index ranges: currents first, then voltages, then derived ones
  localparam logic [5:0]  SRC_CUR_LAST  = 6'h17;
  localparam logic [5:0]  SRC_VOLT_LAST = 6'h2F;
  localparam logic [1:0]  KIND_BOTH = 2'h0;
  localparam logic [1:0]  KIND_CUR  = 2'h1;
  localparam logic [1:0]  KIND_VOLT = 2'h2;
  localparam logic [3:0]  DEPTH_CNT = 4'hC;

  typedef enum logic [2:0] {
    OC_NONE = 3'h0, OC_AG = 3'h1, OC_BG = 3'h2, OC_AB = 3'h3,
    OC_CG = 3'h4, OC_AC = 3'h5, OC_BC = 3'h6, OC_ABC = 3'h7
  } oc_fault_e;

  typedef enum logic [3:0] {
    VF_NONE = 4'h0, VF_A = 4'h1, VF_B = 4'h2, VF_AB = 4'h3, VF_C = 4'h4,
    VF_AC = 4'h5, VF_BC = 4'h6, VF_ABC = 4'h7, VF_OVER_F = 4'h8,
    VF_UNDER_F = 4'h9, VF_OVER_P = 4'hA, VF_UNDER_P = 4'hB, VF_THERMAL = 4'hC,
    VF_UNBAL = 4'hD, VF_HARM = 4'hE, VF_RESID = 4'hF
  } volt_fault_e;

  // stage classes for the display decision
  typedef enum logic [3:0] {
    ST_NONE = 4'h0, ST_OVERCUR = 4'h1, ST_UNBAL = 4'h2, ST_DIR_OC = 4'h3,
    ST_EARTH = 4'h4, ST_DIR_EARTH = 4'h5, ST_UNDER_F = 4'h6, ST_OVER_F = 4'h7,
    ST_UNDER_V = 4'h8, ST_OVER_V = 4'h9, ST_SEQ_V = 4'hA, ST_RESID_V = 4'hB,
    ST_OVER_P = 4'hC, ST_UNDER_P = 4'hD, ST_REV_P = 4'hE, ST_THERMAL = 4'hF
  } stage_class_e;

  typedef struct packed {
    logic [CHANNELS-1:0][MAG_W-1:0] mag;
    logic [STAGE_W-1:0]             stage;
    stage_class_e                   stage_class;
    oc_fault_e                      oc_code;
    volt_fault_e                    volt_code;
    logic                           primary;
    logic [TS_W-1:0]                stamp_ms;
    logic [GROUP_W-1:0]             group;
    logic                           shows_values;
    logic                           valid;
  } record_s;

  typedef struct packed {
    logic [STAGE_W-1:0] stage;
    oc_fault_e          oc_code;
    volt_fault_e        volt_code;
    logic               strobe;
  } upstream_s;
endpackage : fault_rec_pkg

// File: src/fault_snapshot_recorder.sv
// Trigger-driven snapshot recorder: twelve newest fault records.
// Assumes measurement magnitudes arrive as flat per-source vectors in both
// per-unit and primary scaling, synchronous to ref_clk.
`timescale 1ns/100ps
module fault_snapshot_recorder #(
  parameter int unsigned MS_DIV = fault_rec_pkg::MS_CYCLES
) (
  input  wire logic                                                             ref_clk,
  input  wire logic                                                             sys_rst,
  input  wire logic                                                             trip_in,
  input  wire logic                                                             user_trig,
  input  wire logic                                                             trig_sel_user,
  input  wire logic                                                             use_primary,
  input  wire logic                                                             oc_code_en,
  input  wire logic                                                             volt_code_en,
  input  wire logic [1:0]                                                       variant_kind,
  input  wire logic [fault_rec_pkg::CHANNELS-1:0][fault_rec_pkg::SRC_W-1:0]     chan_src,
  input  wire logic [fault_rec_pkg::SRC_COUNT-1:0][fault_rec_pkg::MAG_W-1:0]    meas_pu,
  input  wire logic [fault_rec_pkg::SRC_COUNT-1:0][fault_rec_pkg::MAG_W-1:0]    meas_pri,
  input  wire logic [fault_rec_pkg::STAGE_W-1:0]                                trip_stage,
  input  wire fault_rec_pkg::stage_class_e                                      trip_class,
  input  wire fault_rec_pkg::oc_fault_e                                         oc_fault,
  input  wire fault_rec_pkg::volt_fault_e                                       volt_fault,
  input  wire logic [fault_rec_pkg::GROUP_W-1:0]                                setting_group,
  input  wire logic [3:0]                                                       view_index,
  output fault_rec_pkg::record_s                                                fault_history_view,
  output logic [3:0]                                                            record_count,
  output fault_rec_pkg::upstream_s                                              upstream
);
  typedef struct packed {
    fault_rec_pkg::record_s [fault_rec_pkg::DEPTH-1:0] hist;
    logic [3:0]                                        count;
    logic [31:0]                                       ms_div;
    logic [fault_rec_pkg::TS_W-1:0]                    ms;
    logic                                              trig_q;
    fault_rec_pkg::upstream_s                          up;
  } state_s;

  state_s                 st;
  state_s                 next_st;
  logic                   trig_lvl;
  logic                   trig_edge;
  fault_rec_pkg::record_s fresh;

  // selected trigger, captured on its rising edge in the same cycle
  assign trig_lvl  = trig_sel_user ? user_trig : trip_in;
  assign trig_edge = trig_lvl && !st.trig_q;

  // per-channel source legality and sampling
  genvar g;
  generate
    for (g = 0; g < fault_rec_pkg::CHANNELS; g++) begin : g_chan
      // one legality flag per channel, so each process owns its own variable
      logic src_ok;
      always_comb begin
        unique case (variant_kind)
          fault_rec_pkg::KIND_CUR:  src_ok = (chan_src[g] <= fault_rec_pkg::SRC_CUR_LAST);
          fault_rec_pkg::KIND_VOLT: src_ok = (chan_src[g] > fault_rec_pkg::SRC_CUR_LAST) &&
                                             (chan_src[g] <= fault_rec_pkg::SRC_VOLT_LAST);
          default:                  src_ok = 1'b1;
        endcase
      end
      // illegal source reads zero rather than a meaningless value
      assign fresh.mag[g] = !src_ok ? '0 :
                            use_primary ? meas_pri[chan_src[g]] : meas_pu[chan_src[g]];
    end
  endgenerate

  // record assembled from present inputs
  assign fresh.stage        = trip_stage;
  assign fresh.stage_class  = trip_class;
  assign fresh.oc_code      = oc_code_en ? oc_fault : fault_rec_pkg::OC_NONE;
  assign fresh.volt_code    = volt_code_en ? volt_fault : fault_rec_pkg::VF_NONE;
  assign fresh.primary      = use_primary;
  assign fresh.stamp_ms     = st.ms;
  assign fresh.group        = setting_group;
  assign fresh.shows_values = (trip_class != fault_rec_pkg::ST_NONE);
  assign fresh.valid        = 1'b1;

  // next-state: ms timebase, history shift, upstream report
  always_comb begin
    next_st        = st;
    next_st.trig_q = trig_lvl;
    next_st.up.strobe = 1'b0;
    if (st.ms_div >= MS_DIV - 1) begin
      next_st.ms_div = '0;
      next_st.ms     = st.ms + 1'b1;
    end else begin
      next_st.ms_div = st.ms_div + 1'b1;
    end
    if (trig_edge) begin
      // shift drops the oldest when full, newest stays at index 0
      for (int i = fault_rec_pkg::DEPTH - 1; i > 0; i--) begin
        next_st.hist[i] = st.hist[i-1];
      end
      next_st.hist[0] = fresh;
      if (st.count != fault_rec_pkg::DEPTH_CNT) begin
        next_st.count = st.count + 1'b1;
      end
      next_st.up.stage     = fresh.stage;
      next_st.up.oc_code   = fresh.oc_code;
      next_st.up.volt_code = fresh.volt_code;
      next_st.up.strobe    = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // display read port; out-of-range index shows an empty record
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_history_view <= '0;
    end else if (view_index < fault_rec_pkg::DEPTH_CNT) begin
      fault_history_view <= st.hist[view_index];
    end else begin
      fault_history_view <= '0;
    end
  end

  assign record_count = st.count;
  assign upstream     = st.up;

  chk_capture_newest: assert property (@(posedge ref_clk) disable iff (sys_rst)
    trig_edge |=> st.hist[0].valid && st.hist[0].stamp_ms == $past(st.ms))
    else $error("capture did not land in newest slot");
  chk_immediate_mag: assert property (@(posedge ref_clk) disable iff (sys_rst)
    trig_edge |=> st.hist[0].mag == $past(fresh.mag))
    else $error("magnitudes not sampled on trigger cycle");
  chk_source_select: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (trig_sel_user && !user_trig) |=> !st.up.strobe || $past(st.trig_q))
    else $error("unselected trigger started a record");
  chk_scaling_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
    trig_edge |=> st.hist[0].primary == $past(use_primary))
    else $error("scaling choice not recorded");
  chk_code_enables: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (trig_edge && !oc_code_en) |=> st.hist[0].oc_code == fault_rec_pkg::OC_NONE)
    else $error("disabled fault code stored");
  chk_upstream_report: assert property (@(posedge ref_clk) disable iff (sys_rst)
    trig_edge |=> st.up.strobe && st.up.stage == st.hist[0].stage)
    else $error("upstream report missing");
  chk_count_limit: assert property (@(posedge ref_clk) disable iff (sys_rst)
    record_count <= fault_rec_pkg::DEPTH_CNT)
    else $error("record count exceeds depth");
  chk_shift_order: assert property (@(posedge ref_clk) disable iff (sys_rst)
    trig_edge |=> st.hist[1] == $past(st.hist[0]))
    else $error("history not shifted newest first");
  chk_group_stamp: assert property (@(posedge ref_clk) disable iff (sys_rst)
    trig_edge |=> st.hist[0].group == $past(setting_group))
    else $error("setting group not stored");

  // further guards: counting, retriggering, code pass-through, channel picks, history shift, timebase, empty history and the display
  // port; those keyed to the trigger edge watch the registered state one cycle after it,
  // which is where the record and the report become visible

  // count steps by one per trigger until the history is full
  chk_count_step: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (trig_edge && st.count != fault_rec_pkg::DEPTH_CNT) |=> st.count == $past(st.count) + 4'h1)
    else $error("record count did not step");
  // no trigger, no change in the number held
  chk_count_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !trig_edge |=> $stable(st.count))
    else $error("record count moved without trigger");
  // a level held high never starts a second record
  chk_no_retrigger: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st.trig_q && trig_lvl) |=> !st.up.strobe)
    else $error("held trigger level retriggered");
  // disabled voltage code is stored as none
  chk_volt_enable: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (trig_edge && !volt_code_en) |=> st.hist[0].volt_code == fault_rec_pkg::VF_NONE)
    else $error("disabled voltage code stored");
  // enabled overcurrent code passes unchanged
  chk_oc_pass: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (trig_edge && oc_code_en) |=> st.hist[0].oc_code == $past(oc_fault))
    else $error("overcurrent code altered");
  // enabled voltage code passes unchanged
  chk_volt_pass: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (trig_edge && volt_code_en) |=> st.hist[0].volt_code == $past(volt_fault))
    else $error("voltage code altered");
  // upstream codes match the newest record
  chk_up_codes: assert property (@(posedge ref_clk) disable iff (sys_rst)
    trig_edge |=> st.up.oc_code == st.hist[0].oc_code && st.up.volt_code == st.hist[0].volt_code)
    else $error("upstream codes differ from record");
  // display flag follows the tripping stage class
  chk_display_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
    trig_edge |=> st.hist[0].shows_values == ($past(trip_class) != fault_rec_pkg::ST_NONE))
    else $error("display flag wrong for stage");
  // last channel with no variant limit picks the chosen source and scaling
  chk_channel_pick: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (trig_edge && variant_kind == fault_rec_pkg::KIND_BOTH) |=>
    st.hist[0].mag[7] == $past(use_primary ? meas_pri[chan_src[7]] : meas_pu[chan_src[7]]))
    else $error("channel source pick wrong");
  // current-only variant refuses a non-current source on channel zero
  chk_illegal_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (trig_edge && variant_kind == fault_rec_pkg::KIND_CUR && chan_src[0] > fault_rec_pkg::SRC_CUR_LAST)
    |=> st.hist[0].mag[0] == '0)
    else $error("illegal source not zeroed");
  // oldest slot takes the one before it, so the twelfth drops out
  chk_shift_tail: assert property (@(posedge ref_clk) disable iff (sys_rst)
    trig_edge |=> st.hist[11] == $past(st.hist[10]))
    else $error("tail of history not shifted");
  // millisecond counter advances once per divider wrap
  chk_ms_tick: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st.ms_div >= MS_DIV - 1) |=> st.ms == $past(st.ms) + 1)
    else $error("millisecond stamp did not advance");
  // display port follows the indexed record one cycle later
  chk_view_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (view_index < fault_rec_pkg::DEPTH_CNT) |=> fault_history_view == $past(st.hist[view_index]))
    else $error("display port lags or wrong");
  // index past the history shows an empty record
  chk_view_range: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (view_index >= fault_rec_pkg::DEPTH_CNT) |=> fault_history_view == '0)
    else $error("out of range index shows data");
  // channel zero of the newest record, with no variant limit, holds its chosen source in the chosen scaling
  chk_primary_pick: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (trig_edge && variant_kind == fault_rec_pkg::KIND_BOTH) |=>
    st.hist[0].mag[0] == $past(use_primary ? meas_pri[chan_src[0]] : meas_pu[chan_src[0]]))
    else $error("scaling choice not applied");
  // empty history holds no valid newest record
  chk_empty_invalid: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st.count == 4'h0) |-> !st.hist[0].valid)
    else $error("valid record with empty count");
endmodule : fault_snapshot_recorder

// File: verification/meas_source_model.sv
// Behavioural stand-in for the measurement calculation logic.
// Assumes the bench supplies a base value that changes only on clock edges.
`timescale 1ns/100ps
module meas_source_model (
  input  wire logic [15:0]                                                   base,
  output logic [fault_rec_pkg::SRC_COUNT-1:0][fault_rec_pkg::MAG_W-1:0]      meas_pu,
  output logic [fault_rec_pkg::SRC_COUNT-1:0][fault_rec_pkg::MAG_W-1:0]      meas_pri
);
  // every source distinct so a wrong pick or wrong scaling shows up
  always_comb begin
    for (int i = 0; i < fault_rec_pkg::SRC_COUNT; i++) begin
      meas_pu[i]  = base + 16'(i);
      meas_pri[i] = ~base + 16'(i);
    end
  end
endmodule : meas_source_model

// File: verification/tb_fault_snapshot_recorder.sv
// Self-checking bench for the fault snapshot recorder.
// Assumes the assertions live in the design and the clock is 100 MHz.
`timescale 1ns/100ps
module tb_fault_snapshot_recorder;
  logic                         ref_clk = 1'b0;
  logic                         sys_rst = 1'b1;
  logic                         trip_in = 1'b0, user_trig = 1'b0, trig_sel_user = 1'b0, use_primary = 1'b0;
  logic                         oc_code_en = 1'b0, volt_code_en = 1'b0;
  logic [1:0]                   variant_kind = 2'h0;
  logic [7:0][5:0]              chan_src = '0;
  logic [63:0][15:0]            meas_pu, meas_pri;
  logic [5:0]                   trip_stage = 6'h00;
  fault_rec_pkg::stage_class_e  trip_class = fault_rec_pkg::ST_NONE;
  fault_rec_pkg::oc_fault_e     oc_fault = fault_rec_pkg::OC_NONE;
  fault_rec_pkg::volt_fault_e   volt_fault = fault_rec_pkg::VF_NONE;
  logic [2:0]                   setting_group = 3'h0;
  logic [3:0]                   view_index = 4'h0, record_count;
  logic [15:0]                  base = 16'h0000;
  logic [31:0]                  seed = 32'h9ACC;
  fault_rec_pkg::record_s       fault_history_view, e, q[$], sent[$];
  fault_rec_pkg::upstream_s     upstream;
  int                           fails = 0, checked = 0, n = 0, cyc = 0, stamp_exp = 0;
  localparam int                MS_DIV = 4;

  always #5 ref_clk = ~ref_clk;

  meas_source_model model (.base(base), .meas_pu(meas_pu), .meas_pri(meas_pri));
  fault_snapshot_recorder #(.MS_DIV(MS_DIV)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .trip_in(trip_in),
    .user_trig(user_trig), .trig_sel_user(trig_sel_user), .use_primary(use_primary), .oc_code_en(oc_code_en),
    .volt_code_en(volt_code_en), .variant_kind(variant_kind), .chan_src(chan_src), .meas_pu(meas_pu),
    .meas_pri(meas_pri), .trip_stage(trip_stage), .trip_class(trip_class), .oc_fault(oc_fault),
    .volt_fault(volt_fault), .setting_group(setting_group), .view_index(view_index),
    .fault_history_view(fault_history_view), .record_count(record_count), .upstream(upstream));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // expected capture of one source under the present variant and scaling
  function automatic logic [15:0] mval(input logic [5:0] s);
    logic ok;
    ok = variant_kind == 2'h0 || (variant_kind == 2'h1 && s <= 6'h17)
      || (variant_kind == 2'h2 && s >= 6'h18 && s <= 6'h2F);
    return !ok ? 16'h0000 : use_primary ? ~base + 16'(s) : base + 16'(s);
  endfunction : mval

  // edges since reset release, for the expected millisecond stamp
  always @(posedge ref_clk) begin
    if (!sys_rst) cyc <= cyc + 1;
  end

  task automatic chk(input string what, input logic [255:0] seen, input logic [255:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  // decoy pulse on the unselected source first, then one real trigger
  task automatic fire(input logic usr);
    fault_rec_pkg::record_s x;
    logic [31:0] r;
    r = rnd();
    trig_sel_user <= usr;
    use_primary <= r[0];
    {oc_code_en, volt_code_en} <= r[2:1];
    {trip_stage, setting_group} <= r[12:4];
    trip_class <= fault_rec_pkg::stage_class_e'(r[16:13]);
    oc_fault <= fault_rec_pkg::oc_fault_e'(r[19:17]);
    volt_fault <= fault_rec_pkg::volt_fault_e'(r[23:20]);
    chan_src <= 48'({rnd(), rnd()});
    base <= r[31:16];
    if (usr) trip_in <= 1'b1;
    else user_trig <= 1'b1;
    @(posedge ref_clk);
    {trip_in, user_trig} <= 2'b00;
    @(posedge ref_clk);
    x = '0;
    for (int c = 0; c < 8; c++) x.mag[c] = mval(chan_src[c]);
    x.stage = trip_stage;
    x.stage_class = trip_class;
    x.oc_code = oc_code_en ? oc_fault : fault_rec_pkg::OC_NONE;
    x.volt_code = volt_code_en ? volt_fault : fault_rec_pkg::VF_NONE;
    {x.primary, x.group, x.valid} = {use_primary, setting_group, 1'b1};
    x.shows_values = trip_class != fault_rec_pkg::ST_NONE;
    q.push_back(x);
    sent.push_back(x);
    if (usr) user_trig <= 1'b1;
    else trip_in <= 1'b1;
    @(posedge ref_clk);
    base <= 16'(rnd()); // sampled values must be those of the trigger edge
    {trip_in, user_trig} <= 2'b00;
    repeat (4) @(posedge ref_clk);
  endtask : fire

  // result watcher: each strobe consumes the oldest note
  always @(posedge ref_clk) begin
    if (!sys_rst && upstream.strobe === 1'b1) begin
      chk("strobe_expected", q.size() != 0, 1'b1);
      if (q.size() != 0) begin
        e = q.pop_front();
        n++;
        chk("up_stage", upstream.stage, e.stage);
        chk("up_codes", {upstream.oc_code, upstream.volt_code}, {e.oc_code, e.volt_code});
        chk("count", record_count, n > 12 ? 12 : n);
        stamp_exp = (cyc - 1) / MS_DIV;
        repeat (2) @(posedge ref_clk);
        chk("view_stamp", fault_history_view.stamp_ms, stamp_exp);
        chk("view_mag", fault_history_view.mag, e.mag);
        chk("view_stage", {fault_history_view.stage, fault_history_view.stage_class}, {e.stage, e.stage_class});
        chk("view_codes", {fault_history_view.oc_code, fault_history_view.volt_code}, {e.oc_code, e.volt_code});
        chk("view_flags", {fault_history_view.primary, fault_history_view.group, fault_history_view.valid},
          {e.primary, e.group, e.valid});
        chk("view_shows", fault_history_view.shows_values, e.shows_values);
      end
    end
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk("count_reset", record_count, 4'h0);
    // thirteen triggers overflow the twelve-deep history
    for (int i = 0; i < 13; i++) begin
      variant_kind <= 2'(i % 3);
      fire(i[0]);
    end
    view_index <= 4'hB;
    repeat (3) @(posedge ref_clk);
    chk("oldest_kept", fault_history_view.mag, sent[1].mag);
    view_index <= 4'hC;
    repeat (3) @(posedge ref_clk);
    chk("beyond_depth", fault_history_view, '0);
    tally_and_finish();
  end

  // watchdog well past the hundred or so cycles the sequence needs
  initial begin
    #50us;
    fails++;
    tally_and_finish();
  end
endmodule : tb_fault_snapshot_recorder
